// ### gpmux_top.sv
// General-purpose pin function multiplexer for two configurable pins
`timescale 1ns/1ps

// Summary of operation
// - Each pin independently input or output, except pin0 codes 0111/1111, which take both pins
// - Bits 7:4 pin 1, 3:0 pin 0
// - Status output keeps status bit polarity, except codes 1011/1100, which are active low
// - Invert flag flips only output pins
// - Pin input replaces internal control bit
// - Code 0001 forces holdover when high
// - Code 0010 forces control voltage mid
// - Pin0 code 0111: both pins select reference
// - Pin selection overrides programmed reference selection
// - Codes 1000/1001 show each PLL lock
// - Code 1010 high when both locked
// - Code 1011 low on enabled input LOS
// - Code 1100 low while in holdover
// - Code 1101 high on unmasked latched status
// - Pin0 code 1111: both pins show reference
// - Reset codes: pin0 1011, pin1 1010
// - Interrupt output holds until sources cleared
module gpmux_top (
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_n_in,
    // Configuration register port
    input  wire logic                  sel_we_in,
    input  wire logic [7:0]            sel_wdata_in,
    output logic      [7:0]            pin_function_select_out,
    input  wire logic                  output_invert_in,
    // Internal controls and status
    input  wire logic                  pll0_vctrl_force_bit_in,
    input  wire logic                  force_hold_bit_in,
    input  wire logic [1:0]            auto_manual_select_in,
    input  wire logic [1:0]            input_disable_in,
    input  wire gpmux_pkg::gpmux_status_s status_in,
    output gpmux_pkg::gpmux_ctrl_s     ctrl_out,
    // Pins
    input  wire logic [1:0]            pin_in,
    output logic      [1:0]            pin_out,
    output logic      [1:0]            pin_oe_out
);

    // All state of the mux
    typedef struct packed {
        logic [7:0]            sel;   // Function select field
        logic [1:0]            po;    // Pin drive level
        logic [1:0]            oe;    // Pin drive enable
        gpmux_pkg::gpmux_ctrl_s ctrl; // Controls toward PLL logic
    } gpmux_state_s;

    gpmux_state_s st;       // Registered state
    gpmux_state_s next_st;  // Next state
    logic [1:0]   pin_lvl;  // Synchronised pin levels

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser; pins come from the board's domain
    gpmux_sync #(
        .W (2)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .raw_in     (pin_in),
        .clean_out  (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode a function code into a status level
    function automatic logic [1:0] out_level(
        input logic [3:0]               code,
        input gpmux_pkg::gpmux_status_s s,
        input logic [1:0]               dis
    );
        // Bit 1 is the drive enable, bit 0 the level
        logic [1:0] r;
        r = 2'h0;
        unique case (code)
            gpmux_pkg::FN_LOCK_JIT:  r = {1'b1, s.jit_locked};
            gpmux_pkg::FN_LOCK_SYN:  r = {1'b1, s.syn_locked};
            gpmux_pkg::FN_LOCK_BOTH:
                r = {1'b1, s.jit_locked & s.syn_locked};
            gpmux_pkg::FN_ACT_ALARM:
                r = {1'b1, ~|(s.los & ~dis)};
            gpmux_pkg::FN_HOLDOVER:  r = {1'b1, ~s.in_holdover};
            // Level follows pending sources, so it holds until all clear
            gpmux_pkg::FN_INTERRUPT: r = {1'b1, s.irq_pending};
            default:                 r = 2'h0;
        endcase
        return r;
    endfunction : out_level

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for pins, controls and configuration
    always_comb
    begin
        logic [3:0] code [2];
        logic [1:0] lv;
        next_st = st;
        code[0] = st.sel[gpmux_pkg::PIN0_LSB +: gpmux_pkg::FUNC_W];
        code[1] = st.sel[gpmux_pkg::PIN1_LSB +: gpmux_pkg::FUNC_W];
        lv      = 2'h0;

        // Software write of the select field
        if (sel_we_in)
        begin
            next_st.sel = sel_wdata_in;
        end

        // Internal controls are the defaults unless a pin replaces them
        next_st.ctrl.force_hold  = force_hold_bit_in;
        next_st.ctrl.vctrl_force = pll0_vctrl_force_bit_in;
        next_st.ctrl.ref_sel     = auto_manual_select_in;
        next_st.po = 2'h0;
        next_st.oe = 2'h0;

        if (code[0] == gpmux_pkg::FN_MAN_REF_SEL)
        begin
            // Both pins form the reference select input
            next_st.ctrl.ref_sel = pin_lvl;
        end
        else if (code[0] == gpmux_pkg::FN_SEL_REF_OUT)
        begin
            // Both pins show the selected reference
            next_st.oe = 2'h3;
            next_st.po = status_in.ref_selected
                         ^ {2{output_invert_in}};
        end
        else
        begin
            // Per-pin independent function
            for (int i = 0; i < 2; i++)
            begin
                // Conflicting levels on a shared input are the board's
                // problem; the OR merge below is simply what falls out
                if (code[i] == gpmux_pkg::FN_FORCE_HOLD)
                begin
                    if (i == 0 || code[0] != gpmux_pkg::FN_FORCE_HOLD)
                    begin
                        next_st.ctrl.force_hold = 1'b0;
                    end
                end
                if (code[i] == gpmux_pkg::FN_VCTRL_FORCE)
                begin
                    if (i == 0 || code[0] != gpmux_pkg::FN_VCTRL_FORCE)
                    begin
                        next_st.ctrl.vctrl_force = 1'b0;
                    end
                end
            end
            for (int i = 0; i < 2; i++)
            begin
                if (code[i] == gpmux_pkg::FN_FORCE_HOLD)
                begin
                    next_st.ctrl.force_hold =
                        next_st.ctrl.force_hold | pin_lvl[i];
                end
                if (code[i] == gpmux_pkg::FN_VCTRL_FORCE)
                begin
                    next_st.ctrl.vctrl_force =
                        next_st.ctrl.vctrl_force | pin_lvl[i];
                end
                lv = out_level(code[i], status_in, input_disable_in);
                next_st.oe[i] = lv[1];
                // Same polarity as status unless inverted
                next_st.po[i] = lv[1] & (lv[0] ^ output_invert_in);
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            st     <= '0;
            st.sel <= gpmux_pkg::SEL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign pin_function_select_out = st.sel;
    assign pin_out                 = st.po;
    assign pin_oe_out              = st.oe;
    assign ctrl_out                = st.ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    reset_value_a: assert property (@(posedge clk_sys_in)
        $rose(rst_n_in) |-> pin_function_select_out == gpmux_pkg::SEL_RESET)
        else $error("select field not at reset value");

    lock_both_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel == 8'hA0 && !sel_we_in && !output_invert_in)
        |=> pin_out[1] == ($past(status_in.jit_locked)
                           & $past(status_in.syn_locked)))
        else $error("combined lock output wrong");

    hold_force_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel[3:0] == 4'h1 && !sel_we_in)
        // Pin 1 on the same function merges in by OR while levels settle
        |=> ctrl_out.force_hold == ($past(pin_lvl[0])
                                    | ($past(st.sel[7:4]) == 4'h1
                                       && $past(pin_lvl[1]))))
        else $error("force holdover not from pin");

    reserved_idle_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel == 8'h00 && !sel_we_in) |=> pin_oe_out == 2'h0)
        else $error("reserved code drives pin");

    man_ref_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel[3:0] == 4'h7 && !sel_we_in)
        |=> ctrl_out.ref_sel == $past(pin_lvl) && pin_oe_out == 2'h0)
        else $error("manual reference select not from pins");

    ref_out_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel[3:0] == 4'hF && !sel_we_in)
        |=> pin_out == ($past(status_in.ref_selected)
                        ^ {2{$past(output_invert_in)}}))
        else $error("selected reference output wrong");

    irq_out_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel[3:0] == 4'hD && !sel_we_in)
        |=> pin_out[0] == ($past(status_in.irq_pending)
                           ^ $past(output_invert_in)))
        else $error("interrupt output wrong");

    alarm_out_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (st.sel[3:0] == 4'hB && !sel_we_in && !output_invert_in)
        |=> pin_out[0] == ~|($past(status_in.los)
                             & ~$past(input_disable_in)))
        else $error("activity alarm output wrong");

endmodule : gpmux_top

// ### gpmux_pkg.sv
// Package: constants and carrier types for the general-purpose pin mux
package gpmux_pkg;

    // Width of one pin function code
    localparam int FUNC_W = 4;
    // Reset value of the pin function select field
    localparam logic [7:0] SEL_RESET = 8'hAB;
    // Field positions inside the select field
    localparam int PIN1_LSB = 4;
    localparam int PIN0_LSB = 0;

    // Function codes
    localparam logic [3:0] FN_FORCE_HOLD  = 4'h1;
    localparam logic [3:0] FN_VCTRL_FORCE = 4'h2;
    localparam logic [3:0] FN_MAN_REF_SEL = 4'h7;
    localparam logic [3:0] FN_LOCK_JIT    = 4'h8;
    localparam logic [3:0] FN_LOCK_SYN    = 4'h9;
    localparam logic [3:0] FN_LOCK_BOTH   = 4'hA;
    localparam logic [3:0] FN_ACT_ALARM   = 4'hB;
    localparam logic [3:0] FN_HOLDOVER    = 4'hC;
    localparam logic [3:0] FN_INTERRUPT   = 4'hD;
    localparam logic [3:0] FN_SEL_REF_OUT = 4'hF;

    // Reference selection values
    localparam logic [1:0] REF_A = 2'h0;
    localparam logic [1:0] REF_B = 2'h1;

    // Internal status gathered for the output functions
    typedef struct packed {
        logic       jit_locked;   // Jitter PLL lock
        logic       syn_locked;   // Synth PLL lock
        logic [1:0] los;          // Loss of signal per reference
        logic       in_holdover;  // Device in holdover
        logic       irq_pending;  // Unmasked latched status set
        logic [1:0] ref_selected; // Currently selected reference
    } gpmux_status_s;

    // Internal controls produced toward the PLL logic
    typedef struct packed {
        logic       force_hold;   // Force holdover
        logic       vctrl_force;  // Force control voltage to mid
        logic [1:0] ref_sel;      // Manual reference selection
    } gpmux_ctrl_s;

endpackage : gpmux_pkg

// ### gpmux_sync.sv
// Three-stage synchroniser with second/third agreement for pin inputs
`timescale 1ns/1ps

module gpmux_sync #(
    parameter int W = 2  // Number of pins
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    // Raw and clean levels
    input  wire logic [W-1:0] raw_in,
    output logic      [W-1:0] clean_out
);

    // All state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;   // First stage, read only by s2
        logic [W-1:0] s2;   // Second stage
        logic [W-1:0] s3;   // Third stage
        logic [W-1:0] lvl;  // Accepted level
    } gpmux_sync_s;

    gpmux_sync_s st;       // Registered state
    gpmux_sync_s next_st;  // Next state

    ////////////////////////////////////////////////////////////////////////
    // Shift stages; level only moves once stages two and three agree
    always_comb
    begin
        next_st    = st;
        next_st.s1 = raw_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            // Agreement filters a single-cycle glitch
            if (st.s2[i] == st.s3[i])
            begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    // Register with synchronous reset
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign clean_out = st.lvl;

endmodule : gpmux_sync

// ### gpmux_board.sv
// Board-side partner model that drives the pins the device releases
`timescale 1ns/1ps

module gpmux_board (
    // Device enables
    input  wire logic [1:0] dev_oe_in,
    // Wanted levels and same-function flag
    input  wire logic [1:0] want_in,
    input  wire logic       same_in,
    // Board drive
    output logic      [1:0] drv_out,
    output logic      [1:0] oe_out
);
    ////////////////////////////////////////////////////////////////////
    // Drive only while the device lets go, so no fight on the wire
    assign oe_out  = ~dev_oe_in;
    // One level on both pins when they share an input function
    assign drv_out = same_in ? {2{want_in[0]}} : want_in;
endmodule : gpmux_board

// ### gpmux_top_tb.sv
// Self-checking bench for the general-purpose pin mux
`timescale 1ns/1ps

module gpmux_top_tb;
    ////////////////////////////////////////////////////////////////////
    // Stimulus, observed outputs and counters
    logic                     clk_sys_in   = 1'b0;
    logic                     rst_n_in     = 1'b0;
    logic                     sel_we_in    = 1'b0;
    logic [7:0]               sel_wdata_in = 8'h00;
    logic                     inv          = 1'b0;
    logic                     vf_bit       = 1'b0;
    logic                     fh_bit       = 1'b0;
    logic [1:0]               ams          = 2'h0;
    logic [1:0]               dis          = 2'h0;
    gpmux_pkg::gpmux_status_s st           = '0;
    gpmux_pkg::gpmux_ctrl_s   ctrl_out;
    logic [7:0]               sel_out;
    logic [1:0]               pin_wire, pin_out, pin_oe_out;
    logic [1:0]               want = 2'h0;
    logic                     same = 1'b0;
    logic [1:0]               brd_drv, brd_oe;
    logic [1:0]               last_lvl = 2'h0;
    int                       bad_count  = 0;
    int                       n_compared = 0;
    int                       seed       = 10;

    always #20 clk_sys_in = ~clk_sys_in;

    ////////////////////////////////////////////////////////////////////
    // Wire level; undriven wire shows inverse of last level
    always_comb
        for (int i = 0; i < 2; i++)
            pin_wire[i] = pin_oe_out[i] ? pin_out[i] :
                          (brd_oe[i] ? brd_drv[i] : ~last_lvl[i]);
    always @(posedge clk_sys_in)
        last_lvl <= pin_wire;

    gpmux_top u_gpmux_top (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .sel_we_in(sel_we_in), .sel_wdata_in(sel_wdata_in),
        .pin_function_select_out(sel_out), .output_invert_in(inv),
        .pll0_vctrl_force_bit_in(vf_bit), .force_hold_bit_in(fh_bit),
        .auto_manual_select_in(ams), .input_disable_in(dis),
        .status_in(st), .ctrl_out(ctrl_out), .pin_in(pin_wire),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out));

    gpmux_board u_gpmux_board (
        .dev_oe_in(pin_oe_out), .want_in(want), .same_in(same),
        .drv_out(brd_drv), .oe_out(brd_oe));

    ////////////////////////////////////////////////////////////////////
    // Reference model: one pin, returns {drive, level}
    function automatic logic [1:0] fn_out(input logic [3:0] c);
        logic l;
        case (c)
            4'h8: l = st.jit_locked;
            4'h9: l = st.syn_locked;
            4'hA: l = st.jit_locked & st.syn_locked;
            4'hB: l = ~|(st.los & ~dis);
            4'hC: l = ~st.in_holdover;
            4'hD: l = st.irq_pending;
            default: return 2'b00;
        endcase
        return {1'b1, l ^ inv};
    endfunction : fn_out

    // Both pins: {oe1, oe0, out1, out0}
    function automatic logic [3:0] exp_pins(input logic [7:0] s);
        logic [1:0] p0, p1;
        p0 = fn_out(s[3:0]);
        p1 = fn_out(s[7:4]);
        if (s[3:0] == 4'hF)
            return {2'b11, st.ref_selected ^ {2{inv}}};
        if (s[3:0] == 4'h7)
            return 4'h0;
        return {p1[1], p0[1], p1[0], p0[0]};
    endfunction : exp_pins

    // Controls: board level replaces the internal bit
    function automatic logic [3:0] exp_ctrl(input logic [7:0] s);
        logic f, v;
        logic [1:0] r;
        f = fh_bit;
        v = vf_bit;
        r = (s[3:0] == 4'h7) ? brd_drv : ams;
        if (s[3:0] != 4'h7 && s[3:0] != 4'hF)
        begin
            if (s[3:0] == 4'h1 || s[7:4] == 4'h1)
                f = (s[3:0] == 4'h1 & brd_drv[0])
                    | (s[7:4] == 4'h1 & brd_drv[1]);
            if (s[3:0] == 4'h2 || s[7:4] == 4'h2)
                v = (s[3:0] == 4'h2 & brd_drv[0])
                    | (s[7:4] == 4'h2 & brd_drv[1]);
        end
        return {f, v, r};
    endfunction : exp_ctrl

    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [7:0] g, input logic [7:0] e,
                         input string w);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, w, g, e);
        end
    endtask : check

    // Write a code (optionally after a back-to-back decoy), randomise
    task automatic step(input logic [7:0] s, input logic bb);
        int r;
        logic [3:0] ep;
        r = $random(seed);
        @(posedge clk_sys_in);
        sel_we_in    <= 1'b1;
        // Decoy first, so each edge sees one data value only
        if (bb)
        begin
            sel_wdata_in <= ~s;
            @(posedge clk_sys_in);
        end
        sel_wdata_in <= s;
        st     <= gpmux_pkg::gpmux_status_s'(r[7:0]);
        inv    <= r[8];
        vf_bit <= r[9];
        fh_bit <= r[10];
        ams    <= r[12:11];
        dis    <= r[14:13];
        want   <= r[16:15];
        same   <= s[3:0] == s[7:4];
        @(posedge clk_sys_in);
        sel_we_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        #1;
        ep = exp_pins(s);
        check(sel_out, s, "select");
        check({6'h0, pin_oe_out}, {6'h0, ep[3:2]}, "oe");
        check({6'h0, pin_out}, {6'h0, ep[1:0]}, "lvl");
        check({4'h0, ctrl_out}, {4'h0, exp_ctrl(s)}, "ctrl");
    endtask : step

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////
    // Main sequence: reset, every code pair, reset in mid-run
    initial
    begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            repeat (10) @(posedge clk_sys_in);
            #1;
            check(sel_out, 8'hAB, "reset select");
            check({4'h0, pin_oe_out, pin_out}, {4'h0, exp_pins(8'hAB)},
                  "dflt");
            for (int i = 0; i < 256; i++)
                step(i[7:0], i[4]);
            @(posedge clk_sys_in);
            rst_n_in <= 1'b0;
            repeat (4) @(posedge clk_sys_in);
            #1;
            check({6'h0, pin_oe_out}, 8'h00, "oe in reset");
            check(sel_out, 8'hAB, "select in reset");
            // Release on an edge, as every other input
            @(posedge clk_sys_in);
            rst_n_in <= 1'b1;
        end
        final_report();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule : gpmux_top_tb
